//--- design/sram_host_ctrl.sv
`timescale 1ns/1ps
`include "sram_host_defines.svh"

// Operation
// R1 - A high chip select deselects the memory, so the controller holds it high between accesses.
// R2 - With chip select low, the write strobe is driven low for a write and held high for a read.
// R3 - An 18-bit word address is presented and held steady for the whole access.
// R4 - The 16 shared data lines carry controller data on writes and memory data on reads.
// R5 - The upper lane select gates bits 15..8 and the lower lane select gates bits 7..0.
// R6 - The memory drives the data lines only while output enable is low.
// R7 - The memory starts a write only while chip select and write strobe are both low.
// R8 - A write ends at whichever of chip select or write strobe rises first.
// R9 - Write data setup and hold are timed against the rising edge that ends the write.
// R10 - No access is issued until 100 us after power is good.
// R11 - On a read only lanes whose select is low drive data.
// R12 - On a write output enable is ignored and only selected lanes store data.
// R13 - Selected with output enable and write strobe high, no lane is driven.
module sram_host_ctrl
  import sram_host_pkg::*;
#(
  parameter int ADDR_W      = `SRAM_ADDR_W,
  parameter int DATA_W      = `SRAM_DATA_W,
  parameter int POWERUP_CYC = `SRAM_POWERUP_CYC,
  parameter int RD_CYC      = `SRAM_RD_CYC,
  parameter int WR_CYC      = `SRAM_WR_CYC,
  parameter int WAIT_W      = `SRAM_WAIT_W
) (
  input  wire logic              ref_clk_i,
  input  wire logic              nrst_i,
  input  wire logic              req_valid_i,
  input  wire logic              req_write_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  input  wire logic [1:0]        req_lane_en_i,
  output logic                   req_ready_o,
  output logic                   rsp_valid_o,
  output logic [DATA_W-1:0]      rsp_rdata_o,
  output logic [ADDR_W-1:0]      word_addr_o,
  output logic                   chip_sel_n_o,
  output logic                   write_strobe_n_o,
  output logic                   out_enable_n_o,
  output logic                   upper_lane_select_n_o,
  output logic                   lower_lane_select_n_o,
  input  wire logic [DATA_W-1:0] shared_data_i,
  output logic [DATA_W-1:0]      shared_data_o,
  output logic                   shared_data_oe_o
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [WAIT_W-1:0] wait_of(input int cyc);
    wait_of = WAIT_W'(cyc - 1);
  endfunction : wait_of

  function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] en);
    lane_mask = {{(DATA_W/2){en[`SRAM_LANE_HI]}},
                 {(DATA_W/2){en[`SRAM_LANE_LO]}}};
  endfunction : lane_mask

  // ---------------------------------------------------------------
  // sequence state
  // ---------------------------------------------------------------
  ctrl_state_t       state_r;
  ctrl_state_t       state_nxt;
  logic              wait_done;
  logic              wait_load;
  logic [WAIT_W-1:0] wait_val;
  logic              accept;
  logic [1:0]        lane_en_r;

  assign accept    = (state_r == ST_IDLE) && req_valid_i;
  assign wait_load = (state_nxt != state_r);
  assign wait_val  = (state_nxt == ST_RD) ? wait_of(RD_CYC)
                                          : wait_of(WR_CYC);

  // counter comes out of reset already loaded with the power-up wait
  sram_wait_counter #(
    .WIDTH     (WAIT_W),
    .RESET_VAL (WAIT_W'(POWERUP_CYC - 1))
  ) u_wait (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .load_i    (wait_load),
    .value_i   (wait_val),
    .done_o    (wait_done)
  );

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_POWERUP:  if (wait_done) state_nxt = ST_IDLE; // [R10]
      ST_IDLE: begin
        if (accept) begin
          state_nxt = req_write_i ? ST_WR_SETUP : ST_RD; // [R2]
        end
      end
      ST_RD:       if (wait_done) state_nxt = ST_IDLE;
      ST_WR_SETUP: state_nxt = ST_WR_PULSE;
      ST_WR_PULSE: if (wait_done) state_nxt = ST_WR_HOLD;
      ST_WR_HOLD:  state_nxt = ST_IDLE;
      default:     state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r <= ST_POWERUP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------
  // control pins, all registered from the next state
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      chip_sel_n_o     <= 1'b1;
      write_strobe_n_o <= 1'b1;
      out_enable_n_o   <= 1'b1;
      shared_data_oe_o <= 1'b0;
      req_ready_o      <= 1'b0;
    end else begin
      // deselect whenever idle so stray pin levels do nothing
      chip_sel_n_o     <= (state_nxt == ST_IDLE) ||
                          (state_nxt == ST_POWERUP); // [R1] [R10]
      write_strobe_n_o <= (state_nxt != ST_WR_PULSE); // [R2] [R7]
      // output enable stays high on writes to avoid a bus fight
      out_enable_n_o   <= (state_nxt != ST_RD); // [R6] [R12] [R13]
      shared_data_oe_o <= (state_nxt == ST_WR_SETUP) ||
                          (state_nxt == ST_WR_PULSE) ||
                          (state_nxt == ST_WR_HOLD); // [R4] [R9]
      req_ready_o      <= (state_nxt == ST_IDLE);
    end
  end

  // ---------------------------------------------------------------
  // address, lanes and write data, latched at acceptance
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      word_addr_o           <= '0;
      shared_data_o         <= '0;
      lane_en_r             <= 2'h0;
      upper_lane_select_n_o <= 1'b1;
      lower_lane_select_n_o <= 1'b1;
    end else if (accept) begin
      word_addr_o           <= req_addr_i; // [R3]
      shared_data_o         <= req_wdata_i; // [R4]
      lane_en_r             <= req_lane_en_i;
      upper_lane_select_n_o <= !req_lane_en_i[`SRAM_LANE_HI]; // [R5]
      lower_lane_select_n_o <= !req_lane_en_i[`SRAM_LANE_LO]; // [R5]
    end else if (state_nxt == ST_IDLE) begin
      {upper_lane_select_n_o, lower_lane_select_n_o} <= `SRAM_LANES_OFF;
    end
  end

  // ---------------------------------------------------------------
  // response
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= '0;
    end else begin
      rsp_valid_o <= ((state_r == ST_RD) && wait_done) ||
                     (state_r == ST_WR_HOLD);
      if ((state_r == ST_RD) && wait_done) begin
        // unselected lanes float, so they read back as zero
        rsp_rdata_o <= shared_data_i & lane_mask(lane_en_r); // [R11]
      end else if (state_r == ST_WR_HOLD) begin
        rsp_rdata_o <= '0;
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic [WAIT_W-1:0] since_rst_r;

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      since_rst_r <= '0;
    end else if (since_rst_r != {WAIT_W{1'b1}}) begin
      since_rst_r <= since_rst_r + WAIT_W'(1);
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_strobe_low;
    !write_strobe_n_o && !chip_sel_n_o && shared_data_oe_o;
  endsequence

  sequence s_write_close;
    write_strobe_n_o && !chip_sel_n_o && shared_data_oe_o &&
      $stable(shared_data_o);
  endsequence

  a_powerup_wait: assert property ( // [R10]
    !chip_sel_n_o |-> since_rst_r >= WAIT_W'(POWERUP_CYC))
    else $error("access issued before the power-up wait");

  a_idle_deselect: assert property ( // [R1]
    req_ready_o |-> chip_sel_n_o && write_strobe_n_o &&
      !shared_data_oe_o)
    else $error("memory selected while controller idle");

  a_write_order: assert property ( // [R9]
    $fell(write_strobe_n_o) |->
      !$past(chip_sel_n_o) && $past(shared_data_oe_o) ##0
      s_strobe_low[*1] ##1 s_write_close ##1 chip_sel_n_o)
    else $error("write strobe not framed by select and data");

  a_read_drive: assert property ( // [R2]
    !out_enable_n_o |-> !chip_sel_n_o && write_strobe_n_o &&
      !shared_data_oe_o)
    else $error("read cycle with write strobe or data driven");

  a_write_no_oe: assert property ( // [R4]
    shared_data_oe_o |-> out_enable_n_o && !chip_sel_n_o)
    else $error("data driven while memory may drive");

  a_addr_stable: assert property ( // [R3]
    !chip_sel_n_o && !$past(chip_sel_n_o) |->
      $stable(word_addr_o) && $stable(shared_data_o))
    else $error("address or data changed inside an access");

  a_lane_map: assert property ( // [R5]
    req_ready_o && req_valid_i |=>
      upper_lane_select_n_o == !$past(req_lane_en_i[`SRAM_LANE_HI]) &&
      lower_lane_select_n_o == !$past(req_lane_en_i[`SRAM_LANE_LO]))
    else $error("lane selects do not follow the request");

  a_read_done: assert property ( // [R2]
    req_ready_o && req_valid_i && !req_write_i |=>
      !out_enable_n_o ##1 rsp_valid_o && out_enable_n_o)
    else $error("read did not complete in one access cycle");

endmodule : sram_host_ctrl

//--- common/sram_host_defines.svh
`ifndef SRAM_HOST_DEFINES_SVH
`define SRAM_HOST_DEFINES_SVH

// ---------------------------------------------------------------
// clock
// ---------------------------------------------------------------
`define REF_CLK_MHZ        50
`define REF_CLK_PERIOD_NS  20

// ---------------------------------------------------------------
// pin widths and lane positions
// ---------------------------------------------------------------
`define SRAM_ADDR_W        18
`define SRAM_DATA_W        16
`define SRAM_LANES         2
`define SRAM_LANE_LO       0
`define SRAM_LANE_HI       1
`define SRAM_LANES_OFF     2'h3

// ---------------------------------------------------------------
// timing: figures in their own unit, cycle counts derived
// ---------------------------------------------------------------
`define SRAM_TPOWER_US     100
`define SRAM_POWERUP_CYC   (`SRAM_TPOWER_US * `REF_CLK_MHZ)
`define SRAM_TAA_NS        20
`define SRAM_RD_CYC        ((`SRAM_TAA_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)
`define SRAM_TPWE_NS       10
`define SRAM_WR_CYC        ((`SRAM_TPWE_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)
`define SRAM_WAIT_W        13

`endif

//--- common/sram_host_pkg.sv
package sram_host_pkg;

  // ---------------------------------------------------------------
  // controller sequence
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_POWERUP  = 3'b000,
    ST_IDLE     = 3'b001,
    ST_RD       = 3'b010,
    ST_WR_SETUP = 3'b011,
    ST_WR_PULSE = 3'b100,
    ST_WR_HOLD  = 3'b101
  } ctrl_state_t;

endpackage : sram_host_pkg

//--- design/sram_wait_counter.sv
`timescale 1ns/1ps
module sram_wait_counter #(
  parameter int               WIDTH     = 13,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             ref_clk_i,
  input  wire logic             nrst_i,
  input  wire logic             load_i,
  input  wire logic [WIDTH-1:0] value_i,
  output logic                  done_o
);

  logic [WIDTH-1:0] cnt_r;

  // reset value lets the same counter time the power-up wait
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= RESET_VAL;
    end else if (load_i) begin
      cnt_r <= value_i;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - WIDTH'(1);
    end
  end

  assign done_o = (cnt_r == '0);

endmodule : sram_wait_counter

//--- bench/sram_model.sv
`timescale 1ns/1ps
module sram_model (
  input  wire logic        ref_clk_i,
  input  wire logic [17:0] word_addr_i,
  input  wire logic        chip_sel_n_i,
  input  wire logic        write_strobe_n_i,
  input  wire logic        out_enable_n_i,
  input  wire logic        upper_lane_select_n_i,
  input  wire logic        lower_lane_select_n_i,
  input  wire logic [15:0] host_data_i,
  input  wire logic        host_oe_i,
  output logic      [15:0] wire_o
);
  logic [15:0] mem [logic [17:0]];
  logic [15:0] junk = 16'hA5C3;
  logic [15:0] rd;
  logic [1:0]  lane_n;
  logic        wr_open;
  assign lane_n = {upper_lane_select_n_i, lower_lane_select_n_i};
  assign wr_open = !chip_sel_n_i && !write_strobe_n_i;
  // undriven lanes wander so a stale value never passes as data
  always @(posedge ref_clk_i) junk <= ~junk + 16'h1357;
  // store at the end of overlap, whichever strobe rises first
  always @(negedge wr_open) begin
    logic [15:0] w;
    // the first reset edge can fall before the address pins settle
    if (!$isunknown(word_addr_i)) begin
      w = mem.exists(word_addr_i) ? mem[word_addr_i] : 16'h0;
      if (!lane_n[1]) w[15:8] = wire_o[15:8];
      if (!lane_n[0]) w[7:0] = wire_o[7:0];
      mem[word_addr_i] = w;
    end
  end
  always @* begin
    rd = mem.exists(word_addr_i) ? mem[word_addr_i] : junk;
    wire_o = junk;
    if (host_oe_i) wire_o = host_data_i;
    else if (!chip_sel_n_i && !out_enable_n_i && write_strobe_n_i) begin
      if (!lane_n[1]) wire_o[15:8] = rd[15:8];
      if (!lane_n[0]) wire_o[7:0] = rd[7:0];
    end
  end
endmodule : sram_model

//--- bench/async_sram_x16_interface_test.sv
`timescale 1ns/1ps
`include "sram_host_defines.svh"
module async_sram_x16_interface_test;
  localparam int PWR = 8;
  logic ref_clk_i = 1'b0, nrst_i = 1'b1;
  logic req_valid_i = 1'b0, req_write_i = 1'b0;
  logic [17:0] req_addr_i = 18'h0, word_addr_o;
  logic [15:0] req_wdata_i = 16'h0, rsp_rdata_o, sd_in, sd_out;
  logic [1:0] req_lane_en_i = 2'h0;
  logic req_ready_o, rsp_valid_o, chip_sel_n_o, write_strobe_n_o;
  logic out_enable_n_o, up_n, lo_n, sd_oe;
  logic [15:0] shadow [logic [17:0]];
  logic [17:0] pool [8];
  int n_fail = 0, num_checks = 0, cyc = 0, pcnt = 0, seed;

  sram_host_ctrl #(.POWERUP_CYC(PWR)) uut (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
    .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_lane_en_i(req_lane_en_i), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
    .word_addr_o(word_addr_o), .chip_sel_n_o(chip_sel_n_o),
    .write_strobe_n_o(write_strobe_n_o), .out_enable_n_o(out_enable_n_o),
    .upper_lane_select_n_o(up_n), .lower_lane_select_n_o(lo_n),
    .shared_data_i(sd_in), .shared_data_o(sd_out),
    .shared_data_oe_o(sd_oe));
  sram_model mem (.ref_clk_i(ref_clk_i), .word_addr_i(word_addr_o),
    .chip_sel_n_i(chip_sel_n_o), .write_strobe_n_i(write_strobe_n_o),
    .out_enable_n_i(out_enable_n_o), .upper_lane_select_n_i(up_n),
    .lower_lane_select_n_i(lo_n), .host_data_i(sd_out),
    .host_oe_i(sd_oe), .wire_o(sd_in));

  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end

  function automatic logic [15:0] mask(input logic [1:0] l);
    mask = {{8{l[1]}}, {8{l[0]}}};
  endfunction : mask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task automatic chk_data(input logic [15:0] g, e, input string m);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk_data

  task automatic chk_flag(input logic g, e, input string m);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask : chk_flag

  task automatic step();
    @(posedge ref_clk_i);
    #1;
  endtask : step

  task automatic power_wait();
    int k = 0;
    while (req_ready_o !== 1'b1 && k < 100) begin
      step();
      k++;
    end
    req_valid_i = 1'b0;
    chk_flag(k == PWR, 1'b1, "ready after power-up wait");
    // let an edge pass so the next request is a fresh assignment
    step();
  endtask : power_wait

  task automatic access(input logic w, input logic [17:0] a,
                        input logic [15:0] d, input logic [1:0] l);
    int k = 0;
    logic [15:0] e;
    e = w ? 16'h0 : shadow[a] & mask(l);
    req_valid_i = 1'b1;
    req_write_i = w;
    req_addr_i = a;
    req_wdata_i = d;
    req_lane_en_i = l;
    while (req_ready_o !== 1'b1) step();
    step();
    req_valid_i = 1'b0;
    if (w) shadow[a] = (shadow[a] & ~mask(l)) | (d & mask(l));
    while (rsp_valid_o !== 1'b1 && k < 20) begin
      step();
      k++;
    end
    // edges counted after the taking edge
    chk_flag(k == (w ? `SRAM_WR_CYC + 2 : `SRAM_RD_CYC), 1'b1,
             "completion latency");
    chk_flag(chip_sel_n_o, 1'b1, "deselect after access");
    chk_data(rsp_rdata_o, e, "response data");
  endtask : access

  // ---------------------------------------------------------------
  // pin monitor and hang guard
  // ---------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    cyc++;
    pcnt = nrst_i ? pcnt + 1 : 0;
    chk_flag(!chip_sel_n_o && pcnt <= PWR + 1, 1'b0, "early select");
    chk_flag(!out_enable_n_o && sd_oe, 1'b0, "data line fight");
    chk_flag(!write_strobe_n_o && !sd_oe, 1'b0, "write data gone");
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'hc715;
    pool = '{18'h0, 18'h3FFFF, 18'h15555, 18'h2AAAA, 18'h1, 18'h20000,
             18'($random(seed)), 18'($random(seed))};
    req_valid_i = 1'b1; // held through power-up, must be refused
    // a real falling edge, so the asynchronous reset branch fires
    #1 nrst_i = 1'b0;
    repeat (5) step();
    nrst_i = 1'b1;
    power_wait();
    foreach (pool[i]) access(1'b1, pool[i], 16'($random(seed)), 2'h3);
    for (int w = 0; w < 4; w++) begin
      for (int r = 0; r < 4; r++) begin
        access(1'b1, pool[r], 16'($random(seed)), 2'(w));
        access(1'b0, pool[r], 16'h0, 2'(r));
      end
    end
    repeat (60) access(1'($random(seed)), pool[3'($random(seed))],
      16'($random(seed)), 2'($random(seed)));
    // reset in the hold cycle of a write: pins must let go at once
    req_valid_i = 1'b1;
    req_write_i = 1'b1;
    req_addr_i = 18'h00100;
    repeat (3) step();
    nrst_i = 1'b0;
    #1;
    chk_flag(chip_sel_n_o & write_strobe_n_o, 1'b1, "reset select");
    chk_flag(sd_oe, 1'b0, "reset data drive");
    req_valid_i = 1'b0;
    step();
    nrst_i = 1'b1;
    power_wait();
    access(1'b0, pool[1], 16'h0, 2'h3);
    wrap_up();
  end
endmodule : async_sram_x16_interface_test
